/* dv/conv_model.sv */
// Behavioural converter answering the sequencer's start pulse
module conv_model (
   input wire logic i_clock,
   input wire logic i_start,
   input wire logic [7:0] i_delay,
   input wire logic [13:0] i_code,
   output logic o_done = 1'h0,
   output logic [13:0] o_code = 14'h0000
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt_q = 8'h00;
   // Code lines toggle outside the done cycle, so nothing stale looks valid
   always @(posedge i_clock) begin
      o_done <= 1'h0;
      o_code <= ~o_code;
      if (i_start) begin
         cnt_q <= i_delay;
      end else if (cnt_q != 8'h00) begin
         cnt_q <= cnt_q - 8'h01;
         if (cnt_q == 8'h01) begin
            o_done <= 1'h1;
            o_code <= i_code;
         end
      end
   end
endmodule // conv_model

/* dv/sh_channel_sequencer_asserts.sv */
// Port assertions for the channel sequencer
module sh_seq_checker #(
   parameter int CODE_W = 14,
   parameter int ACQ_CYC = 20
) (
   input wire logic i_clock,
   input wire logic i_rstn,
   input wire logic i_conv_done,
   input wire logic o_busy_n,
   input wire logic o_conv_start,
   input wire logic [31:0] o_buffer_from_vin,
   input wire logic [CODE_W-1:0] o_dac_code [0:32],
   input wire logic [CODE_W-1:0] o_offset_channel_output
);
   // Busy low for the whole timeout is the longest legal acquisition
   localparam int ACQ_LIM = ACQ_CYC;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rstn);
   sequence s_start; $fell(o_busy_n) && o_conv_start; endsequence
   sequence s_finish; $rose(o_busy_n) && o_buffer_from_vin == '0; endsequence
   property p_start_low; o_conv_start |-> !o_busy_n; endproperty
   a_start_low: assert property (p_start_low) else $error("start while busy high");
   property p_fell_start; $fell(o_busy_n) |-> o_conv_start; endproperty
   a_fell_start: assert property (p_fell_start) else $error("busy fell, no start");
   property p_start_once; o_conv_start |=> !o_conv_start; endproperty
   a_start_once: assert property (p_start_once) else $error("start too long");
   property p_done_end; !o_busy_n && !o_conv_start && i_conv_done |=> o_busy_n; endproperty
   a_done_end: assert property (p_done_end) else $error("busy stayed low");
   property p_max_acq; s_start |-> ##[1:ACQ_LIM] s_finish; endproperty
   a_max_acq: assert property (p_max_acq) else $error("acquisition too long");
   property p_release; $rose(o_busy_n) |-> o_buffer_from_vin == '0; endproperty
   a_release: assert property (p_release) else $error("input still routed");
   property p_offset; o_offset_channel_output == o_dac_code[32]; endproperty
   a_offset: assert property (p_offset) else $error("offset output differs");
   property p_hold;
      // A reset pulse clears every register at once, which is legal
      o_busy_n && $past(o_busy_n) && o_dac_code[3] != '0 |->
         $stable(o_dac_code[3]) ||
         (o_dac_code[3] == '0 && o_dac_code[0] == '0 && o_offset_channel_output == '0);
   endproperty
   a_hold: assert property (p_hold) else $error("code changed while idle");
endmodule // sh_seq_checker

/* dv/test_sh_channel_sequencer.sv */
// Self-checking bench for the channel sequencer
module test_sh_channel_sequencer import sh_seq_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int ACQ = 20;
   logic i_clock = 1'h0, i_rstn = 1'h0, pin = 1'h1, i_par_load = 1'h0, i_ser_load = 1'h0;
   channel_req_t i_par_req = '0, i_ser_req = '0;
   logic [7:0] delay = 8'h05;
   logic [13:0] code = 14'h0000, conv_code, offs;
   logic [13:0] dac [0:32];
   logic conv_done, busy_n, start;
   logic [31:0] route;
   int failures = 0, tests_run = 0;
   always #5 i_clock = ~i_clock;
   conv_model cm (.i_clock(i_clock), .i_start(start), .i_delay(delay), .i_code(code),
      .o_done(conv_done), .o_code(conv_code));
   sh_channel_sequencer #(.CODE_W(14), .ACQ_CYC(ACQ)) uut (.i_clock(i_clock),
      .i_rstn(i_rstn), .i_track_reset_pin(pin), .i_par_load(i_par_load),
      .i_par_req(i_par_req), .i_ser_load(i_ser_load), .i_ser_req(i_ser_req),
      .i_conv_done(conv_done), .i_conv_code(conv_code), .o_busy_n(busy_n),
      .o_conv_start(start), .o_buffer_from_vin(route), .o_dac_code(dac),
      .o_offset_channel_output(offs));
   // ----------------------------------------
   // Shared steps
   // ----------------------------------------
   task automatic chk(input logic ok, input string m);
      tests_run++;
      if (ok !== 1'h1) begin
         failures++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   // Sampled on the falling edge, clear of the register updates
   task automatic wait_busy(input logic v, input int lim);
      int n;
      n = 0;
      do begin
         @(negedge i_clock);
         n++;
      end while (busy_n !== v && n < lim);
      chk(busy_n === v, "busy wait");
   endtask
   task automatic acq(input logic ser, input channel_req_t r, input logic [13:0] c);
      @(posedge i_clock);
      code <= c;
      i_ser_load <= ser;
      i_par_load <= !ser;
      i_ser_req <= r;
      i_par_req <= r;
      @(posedge i_clock);
      i_ser_load <= 1'h0;
      i_par_load <= 1'h0;
      wait_busy(1'h0, 4);
   endtask
   task automatic low_pin(input int n);
      @(posedge i_clock);
      pin <= 1'h0;
      repeat (n) @(posedge i_clock);
      pin <= 1'h1;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_power_on();
      for (int i = 0; i <= 32; i++) chk(dac[i] === 14'h0000, "not cleared");
   endtask
   task automatic t_single();
      acq(1'h0, '{1'h0, 1'h0, 5'h10}, 14'h1ABC);
      chk(route === 32'h00010000, "route");
      wait_busy(1'h1, ACQ + 4);
      chk(dac[16] === 14'h1ABC && dac[15] === 14'h0000, "parallel");
   endtask
   task automatic t_serial();
      acq(1'h1, '{1'h0, 1'h0, 5'h03}, 14'h2345);
      wait_busy(1'h1, ACQ + 4);
      chk(dac[3] === 14'h2345 && dac[16] === 14'h1ABC, "serial");
   endtask
   task automatic t_offset();
      acq(1'h0, '{1'h1, 1'h0, 5'h03}, 14'h0F0F);
      wait_busy(1'h1, ACQ + 4);
      chk(offs === 14'h0F0F && dac[3] === 14'h2345, "offset");
   endtask
   task automatic t_cal();
      acq(1'h1, '{1'h0, 1'h1, 5'h00}, 14'h3333);
      wait_busy(1'h1, ACQ + 4);
      chk(dac[0] === 14'h3333 && dac[31] === 14'h3333 && offs === 14'h0F0F, "cal");
   endtask
   task automatic t_timeout();
      delay <= 8'h40;
      acq(1'h0, '{1'h0, 1'h0, 5'h01}, 14'h0123);
      wait_busy(1'h1, ACQ + 3);
      repeat (80) @(posedge i_clock);
      delay <= 8'h05;
   endtask
   task automatic t_glitch();
      low_pin(5);
      repeat (12) @(negedge i_clock);
      chk(dac[0] === 14'h3333, "glitch acted");
      low_pin(8);
      repeat (12) @(negedge i_clock);
      chk(dac[0] === 14'h3333 && busy_n === 1'h1, "80 ns pulse acted");
   endtask
   task automatic t_track();
      low_pin(40);
      repeat (15) @(posedge i_clock);
      pin <= 1'h0;
      repeat (30) @(posedge i_clock);
      i_par_req <= '{1'h0, 1'h0, 5'h07};
      i_par_load <= 1'h1;
      code <= 14'h2AAA;
      @(posedge i_clock);
      i_par_load <= 1'h0;
      repeat (10) @(negedge i_clock);
      chk(busy_n === 1'h1 && route[7] === 1'h1, "track wait");
      @(posedge i_clock);
      pin <= 1'h1;
      wait_busy(1'h0, 10);
      wait_busy(1'h1, ACQ + 4);
      chk(dac[7] === 14'h2AAA, "track code");
   endtask
   task automatic t_reset_pulse();
      low_pin(21);
      repeat (12) @(negedge i_clock);
      chk(dac[7] === 14'h2AAA, "210 ns pulse reset");
      low_pin(15);
      repeat (12) @(negedge i_clock);
      chk(dac[7] === 14'h0000 && dac[0] === 14'h0000 && offs === 14'h0000, "pulse reset");
      acq(1'h0, '{1'h0, 1'h0, 5'h05}, 14'h1111);
      wait_busy(1'h1, ACQ + 4);
      low_pin(9);
      repeat (12) @(negedge i_clock);
      chk(dac[5] === 14'h0000, "90 ns no reset");
      acq(1'h0, '{1'h0, 1'h0, 5'h05}, 14'h1111);
      wait_busy(1'h1, ACQ + 4);
      low_pin(20);
      repeat (12) @(negedge i_clock);
      chk(dac[5] === 14'h0000, "200 ns no reset");
   endtask
   task automatic end_of_test();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      #60000;
      failures++;
      end_of_test();
   end
   initial begin
      repeat (8) @(posedge i_clock);
      i_rstn <= 1'h1;
      @(posedge i_clock);
      t_power_on();
      t_single();
      t_serial();
      t_offset();
      t_cal();
      t_timeout();
      t_glitch();
      t_track();
      t_reset_pulse();
      end_of_test();
   end
endmodule // test_sh_channel_sequencer
bind sh_channel_sequencer sh_seq_checker #(.CODE_W(CODE_W), .ACQ_CYC(ACQ_CYC)) u_checker (
   .i_clock(i_clock), .i_rstn(i_rstn), .i_conv_done(i_conv_done), .o_busy_n(o_busy_n),
   .o_conv_start(o_conv_start), .o_buffer_from_vin(o_buffer_from_vin),
   .o_dac_code(o_dac_code), .o_offset_channel_output(o_offset_channel_output));

/* include/sh_seq_params.svh */
// Constants for the sample-and-hold channel sequencer
// Behaviour
// R1 - Acquisition starts when a channel address loads while track is high.
// R2 - Busy output is low for exactly the acquisition duration.
// R3 - Each acquisition ends within the maximum acquisition time of 16 us.
// R4 - Buffer follows the common input during acquisition, then the DAC drives it.
// R5 - A DAC register changes only when its own channel is acquired again.
// R6 - Power-on clears all 33 DAC registers to zero, offset channel included.
// R7 - Thirty-two channels; the result is written only into the addressed register.
// R8 - Parallel or serial port address starts the same acquisition sequence.
// R9 - Offset channel can be acquired; its DAC drives the offset output.
// R10 - A track/reset low pulse from 90 ns to 200 ns resets all state.
// R11 - A low pulse shorter than 90 ns is a glitch and is ignored.
// R12 - Low longer than 200 ns is track: pass input through, defer acquisition.
// R13 - Address while track low: acquisition begins at the next rising track edge.
// R14 - Five-bit address, top bit most significant, selects one of 32 channels.
// R15 - Calibrate makes all 32 channels acquire the common input together.
// R16 - Low width is counted in clock cycles and classified at rise or limit.
`ifndef SH_SEQ_PARAMS_SVH
`define SH_SEQ_PARAMS_SVH

`define CLK_PERIOD_NS 10
`define GLITCH_MAX_NS 90
`define RESET_MAX_NS 200
`define ACQ_MAX_NS 16000
// Least width rounds up, longest width rounds down
`define GLITCH_CYC ((`GLITCH_MAX_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_CYC (`RESET_MAX_NS / `CLK_PERIOD_NS)
`define ACQ_MAX_CYC (`ACQ_MAX_NS / `CLK_PERIOD_NS)
`define OFFSET_INDEX 32
`define DAC_RESET_CODE 14'h0000

`endif

/* include/sh_seq_pkg.sv */
// Types shared by the sample-and-hold sequencer
package sh_seq_pkg;

   typedef struct packed {
      logic offset_sel;
      logic cal;
      logic [4:0] channel_address_bits;
   } channel_req_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT_TRACK = 2'b01,
      ST_ACQUIRE = 2'b10
   } seq_state_t;

   typedef enum logic [1:0] {
      PULSE_NONE = 2'b00,
      PULSE_GLITCH = 2'b01,
      PULSE_RESET = 2'b10,
      PULSE_TRACK = 2'b11
   } pulse_class_t;

endpackage

/* logic/sh_channel_sequencer.sv */
// Channel sequencer for the 32-channel infinite sample-and-hold
`include "sh_seq_params.svh"

module sh_channel_sequencer import sh_seq_pkg::*; #(
   parameter int CODE_W = 14,
   parameter int ACQ_CYC = `ACQ_MAX_CYC
) (
   input wire logic i_clock,
   input wire logic i_rstn,
   input wire logic i_track_reset_pin,
   input wire logic i_par_load,
   input wire channel_req_t i_par_req,
   input wire logic i_ser_load,
   input wire channel_req_t i_ser_req,
   input wire logic i_conv_done,
   input wire logic [CODE_W-1:0] i_conv_code,
   output logic o_busy_n,
   output logic o_conv_start,
   output logic [31:0] o_buffer_from_vin,
   output logic [CODE_W-1:0] o_dac_code [0:32],
   output logic [CODE_W-1:0] o_offset_channel_output
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      seq_state_t state;
      channel_req_t req;
      logic [13:0] timer;
      logic busy_n;
      logic start;
      logic [31:0] route;
   } seq_t;

   seq_t s_q;
   seq_t s_d;
   logic [CODE_W-1:0] dac_q [0:32];
   logic track_level;
   logic track_rise;
   logic reset_pulse;
   logic load;
   channel_req_t load_req;
   logic finish;
   logic [32:0] write_sel;

   track_reset_filter u_filter (
      .i_clock(i_clock),
      .i_rstn(i_rstn),
      .i_track_pin(i_track_reset_pin),
      .o_track_level(track_level),
      .o_track_rise(track_rise),
      .o_reset_pulse(reset_pulse)
   );

   // Map a request onto the output buffers it drives
   function automatic logic [31:0] route_mask(input channel_req_t r);
      logic [31:0] m;
      m = 32'h00000000;
      if (r.cal) begin
         m = 32'hFFFFFFFF;
      end else if (!r.offset_sel) begin
         // R14 address decode
         m[r.channel_address_bits] = 1'b1;
      end
      return m;
   endfunction

   // ----------------------------------------
   // Sequencing
   // ----------------------------------------
   // R8 either port loads
   assign load = i_par_load | i_ser_load;
   assign load_req = i_par_load ? i_par_req : i_ser_req;
   // Top bit selects the offset register, calibrate leaves it alone
   assign write_sel = {s_q.req.offset_sel && !s_q.req.cal, route_mask(s_q.req)};
   // R3 bounded by timeout
   assign finish = (s_q.state == ST_ACQUIRE) &&
                   (i_conv_done || s_q.timer == 14'(ACQ_CYC - 1));

   always_comb begin
      s_d = s_q;
      s_d.start = 1'b0;
      case (s_q.state)
         ST_IDLE: begin
            if (load) begin
               s_d.req = load_req;
               if (track_level) begin
                  // R1 start on address
                  s_d.state = ST_ACQUIRE;
                  s_d.start = 1'b1;
                  s_d.busy_n = 1'b0;
                  s_d.timer = 14'h0000;
               end else begin
                  // R13 wait for track
                  s_d.state = ST_WAIT_TRACK;
               end
               s_d.route = route_mask(load_req);
            end else if (!track_level) begin
               // R12 track passes input
               s_d.route = route_mask(s_q.req);
            end else begin
               s_d.route = 32'h00000000;
            end
         end
         ST_WAIT_TRACK: begin
            if (load) begin
               s_d.req = load_req;
               s_d.route = route_mask(load_req);
            end
            if (track_rise || track_level) begin
               s_d.state = ST_ACQUIRE;
               s_d.start = 1'b1;
               s_d.busy_n = 1'b0;
               s_d.timer = 14'h0000;
            end
         end
         ST_ACQUIRE: begin
            // R2 busy low throughout
            s_d.timer = s_q.timer + 14'h0001;
            if (finish) begin
               s_d.state = ST_IDLE;
               s_d.busy_n = 1'b1;
               // R4 DAC takes buffer
               s_d.route = 32'h00000000;
            end
         end
         default: begin
            s_d.state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clock) begin
      // R10 pulse resets all
      if (!i_rstn || reset_pulse) begin
         s_q <= '{state: ST_IDLE, req: '0, timer: 14'h0000, busy_n: 1'b1,
                  start: 1'b0, route: 32'h00000000};
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // DAC registers
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g <= 32; g++) begin : g_dac
         always_ff @(posedge i_clock) begin
            // R6 clear 33 registers
            if (!i_rstn || reset_pulse) begin
               dac_q[g] <= CODE_W'(`DAC_RESET_CODE);
            // R5 R7 R9 R15 addressed write only
            end else if (finish && write_sel[g]) begin
               dac_q[g] <= i_conv_code;
            end
         end
         assign o_dac_code[g] = dac_q[g];
      end
   endgenerate

   assign o_busy_n = s_q.busy_n;
   assign o_conv_start = s_q.start;
   assign o_buffer_from_vin = s_q.route;
   // R9 offset output
   assign o_offset_channel_output = dac_q[`OFFSET_INDEX];

endmodule // sh_channel_sequencer

/* logic/track_reset_filter.sv */
// Synchroniser and low-width classifier for the track/reset pin
`include "sh_seq_params.svh"

module track_reset_filter import sh_seq_pkg::*; #(
   parameter int GLITCH_CYC = `GLITCH_CYC,
   parameter int RESET_CYC = `RESET_CYC
) (
   input wire logic i_clock,
   input wire logic i_rstn,
   input wire logic i_track_pin,
   output logic o_track_level,
   output logic o_track_rise,
   output logic o_reset_pulse
);

   typedef struct packed {
      logic [2:0] sync;
      logic level;
      logic long_low;
      logic [7:0] width;
      logic rise;
      logic rst;
   } filt_t;

   filt_t s_q;
   filt_t s_d;

   always_comb begin
      s_d = s_q;
      s_d.sync = {s_q.sync[1:0], i_track_pin};
      s_d.rise = 1'b0;
      s_d.rst = 1'b0;
      // Change counts once the second and third stages agree
      if (s_q.sync[1] == s_q.sync[2]) begin
         s_d.level = s_q.sync[2];
      end
      if (!s_q.level) begin
         // R16 count low width
         if (s_q.width != 8'hFF) begin
            s_d.width = s_q.width + 8'h01;
         end
         // R12 long low is track
         if (s_q.width >= RESET_CYC[7:0]) begin
            s_d.long_low = 1'b1;
         end
      end
      if (!s_q.level && s_d.level) begin
         // Width lags the low cycles by one here, hence the lowered glitch limit
         // R11 short pulse ignored
         // R10 mid-width pulse resets
         if (s_q.long_low || s_q.width >= RESET_CYC[7:0]) begin
            s_d.rise = 1'b1;
         end else if (s_q.width >= 8'(GLITCH_CYC - 1)) begin
            s_d.rst = 1'b1;
         end
         s_d.width = 8'h00;
         s_d.long_low = 1'b0;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         s_q <= '{sync: 3'h7, level: 1'b1, long_low: 1'b0, width: 8'h00,
                  rise: 1'b0, rst: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   // Track is only seen low after the reset window, so glitches and reset pulses never stall
   assign o_track_level = s_q.level | ~s_q.long_low;
   assign o_track_rise = s_q.rise;
   assign o_reset_pulse = s_q.rst;

endmodule // track_reset_filter
